//--- include/cpm_consts.svh
// constants for the channel 2 shared transmit pin mux
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

`define CPM_PIN_BIT        5
`define CPM_BYTE_W         8
`define CPM_FIFO_DEPTH     16
`define CPM_FIFO_WIDTH     10
`define CPM_SYNC_W         15
`define CPM_HDIV_W         2
`define CPM_HDIV_LAST      2'h3
`define CPM_BITCNT_W       13
`define CPM_BITCNT_ONE     13'h0001
`define CPM_BITCNT_ZERO    13'h0000
`define CPM_DS3_FRAME_BITS 4760
`define CPM_E3_FRAME_BITS  1536

`endif

//--- include/cpm_pkg.sv
// types for the channel 2 shared transmit pin mux
package cpm_pkg;

   typedef enum logic [1:0] {
      ROLE_ADD  = 2'b00,
      ROLE_HDLC = 2'b01,
      ROLE_MAP  = 2'b10
   } cpm_role_t;

   typedef enum logic [1:0] {
      KIND_ADD  = 2'b00,
      KIND_HDLC = 2'b01,
      KIND_PAY  = 2'b10
   } cpm_kind_t;

endpackage : cpm_pkg

//--- src/cpm_pin_mux.sv
// shared transmit pin 5 of channel 2: role select, capture paths, frame pulse, fifo
//
// How it works
// [RULE_01] bus enabled: pin is add-bus data bit 5
// [RULE_02] add-bus data latched on add clock falling edge
// [RULE_03] bus disabled: global mode picks input or output
// [RULE_04] hdlc mode: bit 5, device drives byte clock
// [RULE_05] hdlc byte sampled on own clock rising edge
// [RULE_06] far side keeps byte stable at rising edge
// [RULE_07] mapper mode: pulse one bit period, last bit
// [RULE_08] payload bit sampled on payload clock rising edge
`timescale 1ns/1ps
`include "cpm_consts.svh"

// ****************************************************************
// fifo with registered head
// ****************************************************************
module cpm_fifo #(
   parameter int WIDTH = `CPM_FIFO_WIDTH,
   parameter int DEPTH = `CPM_FIFO_DEPTH
) (
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             head_valid_reg;
   logic [WIDTH-1:0] head_data_reg;

   wire do_push = in_valid_i && in_ready_o;
   wire do_pop  = (count_reg != '0) && (!head_valid_reg || out_ready_i);

   assign in_ready_o  = (count_reg != FULL_CNT);
   assign out_valid_o = head_valid_reg;
   assign out_data_o  = head_data_reg;

   always_ff @(posedge clock_i) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
         rd_ptr_reg <= rd_ptr_reg + AW'(do_pop);
         count_reg  <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // head register keeps the data output straight from a flop
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         head_valid_reg <= 1'b0;
         head_data_reg  <= '0;
      end else if (do_pop) begin
         head_valid_reg <= 1'b1;
         head_data_reg  <= mem[rd_ptr_reg];
      end else if (out_ready_i) begin
         head_valid_reg <= 1'b0;
      end
   end

endmodule : cpm_fifo

// ****************************************************************
// top: pin role, capture and frame pulse
// ****************************************************************
module cpm_pin_mux #(
   parameter int DS3_FRAME_BITS = `CPM_DS3_FRAME_BITS,
   parameter int E3_FRAME_BITS  = `CPM_E3_FRAME_BITS
) (
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic                  bus_enable_i,
   input  wire logic                  mode_hdlc_i,
   input  wire logic                  e3_select_i,
   input  wire logic                  add_bus_clock_ch2_i,
   input  wire logic                  tx_payload_input_clock_i,
   input  wire logic                  tx_payload_serial_in_ch2_i,
   input  wire logic [`CPM_BYTE_W-1:0] other_bits_ch2_i,
   input  wire logic                  shared_pin_in_i,
   output logic                       shared_pin_out_o,
   output logic                       shared_pin_oe_n_o,
   output logic                       hdlc_tx_byte_clock_ch2_o,
   output logic [1:0]                 role_o,
   output logic                       overflow_o,
   output logic                       out_valid_o,
   input  wire logic                  out_ready_i,
   output logic [1:0]                 out_kind_o,
   output logic [`CPM_BYTE_W-1:0]     out_data_o
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [`CPM_SYNC_W-1:0] sync1_reg;
   logic [`CPM_SYNC_W-1:0] sync2_reg;
   logic                   aclk_prev_reg;
   logic                   pclk_prev_reg;
   logic [`CPM_BYTE_W-1:0] s_other;
   logic s_e3, s_mode, s_bus, s_pin, s_pdat, s_pclk, s_aclk;

   assign {s_other, s_e3, s_mode, s_bus, s_pin, s_pdat, s_pclk, s_aclk} = sync2_reg;

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg     <= '0;
         sync2_reg     <= '0;
         aclk_prev_reg <= 1'b0;
         pclk_prev_reg <= 1'b0;
      end else begin
         sync1_reg     <= {other_bits_ch2_i, e3_select_i, mode_hdlc_i, bus_enable_i,
                           shared_pin_in_i, tx_payload_serial_in_ch2_i,
                           tx_payload_input_clock_i, add_bus_clock_ch2_i};
         sync2_reg     <= sync1_reg;
         aclk_prev_reg <= s_aclk;
         pclk_prev_reg <= s_pclk;
      end
   end

   function automatic logic [`CPM_BYTE_W-1:0] merge_pin(input logic [`CPM_BYTE_W-1:0] b,
                                                         input logic p);
      logic [`CPM_BYTE_W-1:0] r;
      r = b;
      r[`CPM_PIN_BIT] = p;
      return r;
   endfunction : merge_pin

   // ****************************************************************
   // role selection
   // ****************************************************************
   cpm_pkg::cpm_role_t role_reg;
   cpm_pkg::cpm_role_t role_next;
   logic               oe_n_reg;

   assign role_next = s_bus  ? cpm_pkg::ROLE_ADD :                  // RULE_01
                      s_mode ? cpm_pkg::ROLE_HDLC : cpm_pkg::ROLE_MAP; // RULE_03

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         role_reg <= cpm_pkg::ROLE_ADD;
         oe_n_reg <= 1'b1;
      end else begin
         role_reg <= role_next;
         oe_n_reg <= (role_next != cpm_pkg::ROLE_MAP); // RULE_03
      end
   end

   wire in_add  = (role_reg == cpm_pkg::ROLE_ADD);
   wire in_hdlc = (role_reg == cpm_pkg::ROLE_HDLC);
   wire in_map  = (role_reg == cpm_pkg::ROLE_MAP);
   wire add_fall = in_add && aclk_prev_reg && !s_aclk;  // RULE_02
   wire pay_rise = in_map && !pclk_prev_reg && s_pclk;  // RULE_08

   // ****************************************************************
   // hdlc byte clock
   // ****************************************************************
   logic                   fifo_in_ready;
   logic [`CPM_HDIV_W-1:0] hdiv_reg;
   logic                   hclk_reg;
   logic [1:0]             rise_dly_reg;

   wire hdiv_end = (hdiv_reg == `CPM_HDIV_LAST);
   // a full fifo holds the clock low, so the far side never outruns it
   wire hclk_rise = in_hdlc && hdiv_end && !hclk_reg && fifo_in_ready;
   // leaving the hdlc role drops the clock at once, never left stuck high
   wire hclk_fall = hclk_reg && (hdiv_end || !in_hdlc);
   // data seen two cycles after the edge, the synchroniser depth
   wire hdlc_smp  = in_hdlc && rise_dly_reg[1];  // RULE_05 RULE_06

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         hdiv_reg     <= '0;
         hclk_reg     <= 1'b0;
         rise_dly_reg <= '0;
      end else begin
         hdiv_reg     <= (in_hdlc && !hdiv_end) ? hdiv_reg + 1'b1 : '0;
         hclk_reg     <= (hclk_reg && !hclk_fall) || hclk_rise;  // RULE_04
         rise_dly_reg <= {rise_dly_reg[0], hclk_rise};
      end
   end

   // ****************************************************************
   // frame boundary pulse
   // ****************************************************************
   logic [`CPM_BITCNT_W-1:0] bitcnt_reg;
   logic                     pulse_reg;

   wire [`CPM_BITCNT_W-1:0] frame_last = s_e3 ? `CPM_BITCNT_W'(E3_FRAME_BITS - 1)
                                              : `CPM_BITCNT_W'(DS3_FRAME_BITS - 1);
   wire last_bit = (bitcnt_reg == frame_last);

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         bitcnt_reg <= `CPM_BITCNT_ZERO;
         pulse_reg  <= 1'b0;
      end else if (!in_map) begin
         bitcnt_reg <= `CPM_BITCNT_ZERO;
         pulse_reg  <= 1'b0;
      end else if (pay_rise) begin
         bitcnt_reg <= last_bit ? `CPM_BITCNT_ZERO : bitcnt_reg + `CPM_BITCNT_ONE;
         pulse_reg  <= last_bit;  // RULE_07
      end
   end

   // ****************************************************************
   // capture into the fifo
   // ****************************************************************
   logic                   push_valid_reg;
   logic [1:0]             push_kind_reg;
   logic [`CPM_BYTE_W-1:0] push_data_reg;
   logic                   overflow_reg;

   wire [1:0] kind_next = add_fall ? cpm_pkg::KIND_ADD :
                          hdlc_smp ? cpm_pkg::KIND_HDLC : cpm_pkg::KIND_PAY;
   wire [`CPM_BYTE_W-1:0] data_next = pay_rise ? `CPM_BYTE_W'(s_pdat)
                                               : merge_pin(s_other, s_pin);

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         push_valid_reg <= 1'b0;
         push_kind_reg  <= cpm_pkg::KIND_ADD;
         push_data_reg  <= '0;
         overflow_reg   <= 1'b0;
      end else begin
         push_valid_reg <= add_fall || hdlc_smp || pay_rise;  // RULE_02 RULE_05 RULE_08
         push_kind_reg  <= kind_next;
         push_data_reg  <= data_next;
         overflow_reg   <= overflow_reg || (push_valid_reg && !fifo_in_ready);
      end
   end

   cpm_fifo #(
      .WIDTH (`CPM_FIFO_WIDTH),
      .DEPTH (`CPM_FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .in_valid_i  (push_valid_reg),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({push_kind_reg, push_data_reg}),
      .out_valid_o (out_valid_o),
      .out_ready_i (out_ready_i),
      .out_data_o  ({out_kind_o, out_data_o})
   );

   assign shared_pin_out_o         = pulse_reg;
   assign shared_pin_oe_n_o        = oe_n_reg;
   assign hdlc_tx_byte_clock_ch2_o = hclk_reg;
   assign role_o                   = role_reg;
   assign overflow_o               = overflow_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence add_edge_seq;
      add_fall;
   endsequence

   sequence add_push_seq;
      push_valid_reg && (push_kind_reg == cpm_pkg::KIND_ADD);
   endsequence

   chk_add_role_input: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_01
      in_add |-> oe_n_reg)
      else $error("pin driven while add bus enabled");

   chk_add_fall_latch: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_02
      add_edge_seq |=> add_push_seq ##0 (push_data_reg[`CPM_PIN_BIT] == $past(s_pin)))
      else $error("add bus bit not latched on falling edge");

   chk_mode_pin_dir: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_03
      (!s_bus && !s_mode) |=> !oe_n_reg ##1 1'b1)
      else $error("pin not driven in mapper mode");

   chk_hclk_high_len: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_04
      ($rose(hclk_reg) && in_hdlc) |-> hclk_reg [*4] ##1 !hclk_reg)
      else $error("hdlc clock high phase wrong");

   chk_hdlc_sample: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_05
      ($rose(hclk_reg) && in_hdlc && $stable(role_reg)) |-> ##1 (in_hdlc -> hdlc_smp) ##1
      (in_hdlc -> (push_valid_reg && push_kind_reg == cpm_pkg::KIND_HDLC)))
      else $error("hdlc byte not sampled after clock rise");

   chk_pulse_one_bit: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_07
      ($rose(pulse_reg) && in_map) |=> (pulse_reg throughout (in_map && !pay_rise) [*1]))
      else $error("frame pulse dropped early");

   chk_pulse_end: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_07
      ($fell(pulse_reg) && $past(in_map) && in_map) |-> $past(pay_rise))
      else $error("frame pulse ended off a payload clock edge");

   chk_payload_push: assert property (@(posedge clock_i) disable iff (reset_i) // RULE_08
      pay_rise |=> push_valid_reg && (push_kind_reg == cpm_pkg::KIND_PAY)
      && (push_data_reg[0] == $past(s_pdat)))
      else $error("payload bit not sampled on clock rise");

endmodule : cpm_pin_mux

//--- bench/cpm_far_end.sv
// far-side terminal model feeding the byte-wide transmit bus
`timescale 1ns/1ps
// ****
// far end
// ****
module cpm_far_end #(
   parameter logic [31:0] SEED = 32'h0000_5e11
) (
   input  wire logic       byte_clock_i,
   output logic      [7:0] byte_o
);
   logic [31:0] state_reg;
   initial begin
      state_reg = SEED;
      byte_o    = SEED[7:0];
   end
   // new byte on the fall, so it is settled well before the next rise
   always @(negedge byte_clock_i) begin
      state_reg = state_reg ^ (state_reg << 13);
      state_reg = state_reg ^ (state_reg >> 17);
      state_reg = state_reg ^ (state_reg << 5);
      byte_o    = state_reg[7:0];
   end
endmodule : cpm_far_end

//--- bench/channel_tx_shared_pin_mux_bench.sv
// self-checking bench for the shared transmit pin mux
`timescale 1ns/1ps
// ****
// bench top
// ****
module channel_tx_shared_pin_mux_bench;
   localparam int DS3_LEN = 8;
   localparam int E3_LEN  = 6;
   logic       clock_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       bus_en = 1'b1, mode_hdlc = 1'b0, e3_sel = 1'b0, add_clk = 1'b0;
   logic       pay_clk = 1'b0, pay_bit = 1'b0, tb_pin = 1'b0, out_ready = 1'b0;
   logic       hdlc_ph = 1'b0, stall = 1'b0;
   logic [7:0] tb_bits = 8'h00, far_byte, other_w, out_data;
   logic       pin_out, oe_n, byte_clk, ovf, out_valid, pin_w;
   logic [1:0] role, kind;
   logic [31:0] rng = 32'h0000_a3d6;
   logic [9:0] exp_q[$];
   int         miscompares = 0, total_checks = 0, cycles = 0, rises = 0, n0;

   // pin level resolved from both parties; device drives while oe_n low
   assign pin_w   = !oe_n ? pin_out : (hdlc_ph ? far_byte[5] : tb_pin);
   assign other_w = hdlc_ph ? far_byte : tb_bits;

   cpm_pin_mux #(.DS3_FRAME_BITS(DS3_LEN), .E3_FRAME_BITS(E3_LEN)) i_dut (
      .clock_i(clock_i), .reset_i(reset_i), .bus_enable_i(bus_en), .mode_hdlc_i(mode_hdlc),
      .e3_select_i(e3_sel), .add_bus_clock_ch2_i(add_clk), .tx_payload_input_clock_i(pay_clk),
      .tx_payload_serial_in_ch2_i(pay_bit), .other_bits_ch2_i(other_w),
      .shared_pin_in_i(pin_w), .shared_pin_out_o(pin_out), .shared_pin_oe_n_o(oe_n),
      .hdlc_tx_byte_clock_ch2_o(byte_clk), .role_o(role), .overflow_o(ovf),
      .out_valid_o(out_valid), .out_ready_i(out_ready), .out_kind_o(kind),
      .out_data_o(out_data));
   cpm_far_end i_far (.byte_clock_i(byte_clk), .byte_o(far_byte));

   initial begin
      forever #10 clock_i = ~clock_i;
   end

   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : next_rand

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   // ****
   // watchers
   // ****
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         wrap_up();
      end
   end
   always @(negedge clock_i) begin
      void'(next_rand());
      out_ready <= stall ? 1'b0 : rng[9];
   end
   always @(posedge byte_clk) begin
      rises++;
      if (role === cpm_pkg::ROLE_HDLC) exp_q.push_back({cpm_pkg::KIND_HDLC, far_byte});
   end
   always @(posedge clock_i) begin
      if (!reset_i && out_valid === 1'b1 && out_ready) begin
         if (exp_q.size() == 0) check("spare word", {kind, out_data}, 10'h3ff);
         else check("captured word", {kind, out_data}, exp_q.pop_front());
      end
   end

   // ****
   // drivers
   // ****
   task automatic set_role(input logic en, input logic hd, input logic e3,
                           input logic [1:0] r, input logic oe);
      bus_en = en;
      mode_hdlc = hd;
      e3_sel = e3;
      cyc(5);
      check("role", {8'h00, role}, {8'h00, r});
      check("pin direction", {9'h000, oe_n}, {9'h000, oe});
   endtask : set_role

   task automatic add_byte();
      logic [31:0] r;
      r = next_rand();
      tb_bits = r[7:0];
      tb_pin = r[13];
      add_clk = 1'b1;
      cyc(4);
      add_clk = 1'b0;
      exp_q.push_back({cpm_pkg::KIND_ADD, r[7:6], r[13], r[4:0]});
      cyc(4);
   endtask : add_byte

   task automatic pay_frames(input int len, input int frames);
      logic [31:0] r;
      for (int i = 0; i < len * frames; i++) begin
         r = next_rand();
         pay_bit = r[0];
         cyc(2);
         pay_clk = 1'b1;
         exp_q.push_back({cpm_pkg::KIND_PAY, 7'h00, r[0]});
         cyc(4);
         pay_clk = 1'b0;
         cyc(2);
         check("frame pulse", {9'h000, pin_out}, {9'h000, (i % len) == len - 1});
      end
   endtask : pay_frames

   task automatic drain();
      for (int k = 0; k < 300 && exp_q.size() != 0; k++) cyc(1);
      check("pending words", 10'(exp_q.size()), 10'h000);
   endtask : drain

   // ****
   // main sequence
   // ****
   initial begin
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      reset_i = 1'b0;
      set_role(1'b1, 1'b0, 1'b0, cpm_pkg::ROLE_ADD, 1'b1);
      repeat (12) add_byte();
      drain();
      hdlc_ph = 1'b1;
      set_role(1'b0, 1'b1, 1'b0, cpm_pkg::ROLE_HDLC, 1'b1);
      // consumer stalls: the byte clock must stop instead of dropping bytes
      stall = 1'b1;
      n0 = rises;
      cyc(300);
      check("stalled rises", {9'h000, rises - n0 inside {[14:18]}}, 10'h001);
      stall = 1'b0;
      drain();
      n0 = rises;
      cyc(160);
      check("byte clock rate", {9'h000, rises - n0 inside {[19:21]}}, 10'h001);
      @(negedge byte_clk);
      @(negedge clock_i);
      set_role(1'b0, 1'b0, 1'b0, cpm_pkg::ROLE_MAP, 1'b0);
      hdlc_ph = 1'b0;
      drain();
      pay_frames(DS3_LEN, 3);
      set_role(1'b1, 1'b0, 1'b1, cpm_pkg::ROLE_ADD, 1'b1);
      set_role(1'b0, 1'b0, 1'b1, cpm_pkg::ROLE_MAP, 1'b0);
      pay_frames(E3_LEN, 3);
      drain();
      check("overflow", {9'h000, ovf}, 10'h000);
      wrap_up();
   end
endmodule : channel_tx_shared_pin_mux_bench
